/* File: design/nvm_lock_defs.vh */
// constants for the lock settings and signature row block
`ifndef NVM_LOCK_DEFS_VH
`define NVM_LOCK_DEFS_VH
// apb byte addresses, index times four
`define SIG_IDX_OSC2M_B       6'h00
`define SIG_IDX_OSC2M_A       6'h01
`define SIG_IDX_OSC32K        6'h02
`define SIG_IDX_OSC32M_B      6'h03
`define SIG_IDX_OSC32M_A      6'h04
`define SIG_IDX_LOT0          6'h08
`define SIG_IDX_LOT1          6'h09
`define SIG_IDX_LOT2          6'h0A
`define ADDR_PROT_SETTINGS    8'h40
`define ADDR_CAL_STATUS       8'h44
// field positions in the protection settings byte
`define TBL_FIELD_HI          3
`define TBL_FIELD_LO          2
`define EXT_FIELD_HI          1
`define EXT_FIELD_LO          0
`define PROT_RESET            8'hFF
// field encodings
`define UNLOCKED_SETTING      2'h3
`define WRITE_PROTECT_SETTING 2'h2
`define READ_PROTECT_SETTING  2'h1
`define FULL_PROTECT_SETTING  2'h0
// signature row size in bytes
`define SIG_DEPTH             16
`endif

/* File: design/sig_row_rom.v */
// factory signature row, read only
`timescale 1ns/1ps
`default_nettype none
`include "nvm_lock_defs.vh"
module sig_row_rom #(
	parameter [127:0] CONTENTS = 128'h0000_0000_0033_2211_0000_0000_5544_3322
) (
	// lookup
	input  wire [3:0] addr,
	output wire [7:0] data
);
	wire [7:0] mem [0:`SIG_DEPTH-1];
	genvar i;
	generate
		for (i = 0; i < `SIG_DEPTH; i = i + 1) begin : g_fill
			assign mem[i] = CONTENTS[i*8 +: 8];
		end
	endgenerate
	assign data = mem[addr];
endmodule // sig_row_rom
`default_nettype wire

/* File: design/nvm_lock_sig.v */
// lock settings enforcement and signature row with calibration load
// Notes on behaviour
// - table lock changes only toward stricter
// - table lock cleared only by chip erase or reset
// - 11 allows table writes and reads
// - 10 blocks table writes, reads allowed
// - 01 blocks table reads from boot code
// - 00 blocks table writes and boot reads
// - 01/00, boot vectors: mask irq in app
// - external lock written only by programmer
// - external lock cleared only by chip erase or reset
// - any zero bit blocks test and debug
// - external lock never restricts software access
// - 11 gives programmer no protection
// - 10 refuses programmer writes and fuse writes
// - 00 refuses programmer reads, writes, lock/fuse
// - reset loads 2 MHz cal B
// - reset loads 2 MHz cal A
// - reset loads 32.768 kHz cal
// - reset loads 32 MHz cal B
// - reset loads 32 MHz cal A
// - lot number bytes read only at 08..0A
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "nvm_lock_defs.vh"
module nvm_lock_sig (
	// clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// apb slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	input  wire [3:0]  pstrb,
	output wire        pready,
	output reg  [31:0] prdata,
	output wire        pslverr,
	// external programming interface
	input  wire        prog_wr_lock,
	input  wire [7:0]  prog_lock_data,
	input  wire        chip_erase,
	// cpu access qualifiers
	input  wire        spm_table_req,
	input  wire        lpm_table_req,
	input  wire        exec_in_boot,
	input  wire        vectors_in_boot,
	// programmer access qualifiers
	input  wire        prog_mem_write_req,
	input  wire        prog_mem_read_req,
	input  wire        prog_fuse_write_req,
	input  wire        prog_lock_read_req,
	input  wire        test_if_req,
	input  wire        debug_req,
	// permissions
	output wire        spm_table_allow,
	output wire        lpm_table_allow,
	output wire        irq_mask,
	output wire        sw_mem_allow,
	output wire        prog_mem_write_allow,
	output wire        prog_mem_read_allow,
	output wire        prog_fuse_write_allow,
	output wire        prog_lock_read_allow,
	output wire        test_if_allow,
	output wire        debug_allow,
	// oscillator calibration registers
	output reg  [7:0]  osc2m_cal_b,
	output reg  [7:0]  osc2m_cal_a,
	output reg  [7:0]  osc32k_cal,
	output reg  [7:0]  osc32m_cal_b,
	output reg  [7:0]  osc32m_cal_a,
	output wire        cal_done
);
	localparam [3:0] ST_IDLE  = 4'h1;
	localparam [3:0] ST_LOAD  = 4'h2;
	localparam [3:0] ST_DONE  = 4'h4;
	localparam [3:0] ST_SPARE = 4'h8;

	reg  [7:0] prot_q;
	reg  [7:0] prot_d;
	reg  [3:0] state_q;
	reg  [2:0] step_q;
	reg        wr_lock_s1_q;
	reg        wr_lock_s2_q;
	reg        erase_s1_q;
	reg        erase_s2_q;
	reg  [7:0] lock_data_s1_q;
	reg  [7:0] lock_data_s2_q;
	reg        wr_lock_prev_q;
	reg  [3:0] rom_addr;
	wire [7:0] rom_data;
	wire [1:0] tbl_field;
	wire [1:0] ext_field;
	wire       access;
	wire       prog_wr_pulse;

	sig_row_rom u_rom (
		.addr (rom_addr),
		.data (rom_data)
	);

	assign pready  = 1'b1;
	assign pslverr = 1'b0;
	assign access  = psel & penable;

	// programmer strobes cross from the pin side
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_lock_s1_q   <= 1'b0;
			wr_lock_s2_q   <= 1'b0;
			erase_s1_q     <= 1'b0;
			erase_s2_q     <= 1'b0;
			lock_data_s1_q <= 8'hFF;
			lock_data_s2_q <= 8'hFF;
			wr_lock_prev_q <= 1'b0;
		end else begin
			wr_lock_s1_q   <= prog_wr_lock;
			wr_lock_s2_q   <= wr_lock_s1_q;
			erase_s1_q     <= chip_erase;
			erase_s2_q     <= erase_s1_q;
			lock_data_s1_q <= prog_lock_data;
			lock_data_s2_q <= lock_data_s1_q;
			wr_lock_prev_q <= wr_lock_s2_q;
		end
	end
	assign prog_wr_pulse = wr_lock_s2_q & ~wr_lock_prev_q;

	// protection settings update
	always @* begin
		prot_d = prot_q;
		if (erase_s2_q) begin
			prot_d = `PROT_RESET;
		end else begin
			if (prog_wr_pulse) begin
				prot_d = prot_d & lock_data_s2_q;
			end
			if (access && pwrite && pstrb[0] && paddr == `ADDR_PROT_SETTINGS) begin
				// software may tighten the boot lock fields, never the external field
				prot_d = prot_d & {pwdata[7:2], 2'h3};
			end
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prot_q <= `PROT_RESET;
		end else begin
			prot_q <= prot_d;
		end
	end

	assign tbl_field = prot_q[`TBL_FIELD_HI:`TBL_FIELD_LO];
	assign ext_field = prot_q[`EXT_FIELD_HI:`EXT_FIELD_LO];

	// table section permissions
	assign spm_table_allow = spm_table_req & tbl_field[0];
	assign lpm_table_allow = lpm_table_req &
		~(exec_in_boot & ~tbl_field[1]);
	assign irq_mask = ~tbl_field[1] & vectors_in_boot & ~exec_in_boot;

	// external programming permissions
	assign sw_mem_allow          = 1'b1;
	assign prog_mem_write_allow  = prog_mem_write_req &
		(ext_field == `UNLOCKED_SETTING);
	assign prog_fuse_write_allow = prog_fuse_write_req &
		(ext_field == `UNLOCKED_SETTING);
	assign prog_mem_read_allow   = prog_mem_read_req & ext_field[1];
	assign prog_lock_read_allow  = prog_lock_read_req & ext_field[1];
	assign test_if_allow = test_if_req & (&ext_field);
	assign debug_allow   = debug_req & (&ext_field);

	// calibration load sequencer after reset release
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q      <= ST_IDLE;
			step_q       <= 3'h0;
			osc2m_cal_b  <= 8'h00;
			osc2m_cal_a  <= 8'h00;
			osc32k_cal   <= 8'h00;
			osc32m_cal_b <= 8'h00;
			osc32m_cal_a <= 8'h00;
		end else begin
			case (state_q)
				ST_IDLE: begin
					state_q <= ST_LOAD;
					step_q  <= 3'h0;
				end
				ST_LOAD: begin
					case (step_q)
						3'h0: osc2m_cal_b  <= rom_data;
						3'h1: osc2m_cal_a  <= rom_data;
						3'h2: osc32k_cal   <= rom_data;
						3'h3: osc32m_cal_b <= rom_data;
						default: osc32m_cal_a <= rom_data;
					endcase
					if (step_q == 3'h4) begin
						state_q <= ST_DONE;
					end
					step_q <= step_q + 3'h1;
				end
				ST_DONE: begin
					state_q <= ST_DONE;
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end
	assign cal_done = (state_q == ST_DONE);

	// rom address: loader owns it until done
	always @* begin
		if (state_q != ST_DONE) begin
			rom_addr = {1'b0, step_q};
		end else begin
			rom_addr = paddr[5:2];
		end
	end

	// read data
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			if (paddr == `ADDR_PROT_SETTINGS) begin
				prdata <= {24'h000000, prot_q};
			end else if (paddr == `ADDR_CAL_STATUS) begin
				prdata <= {31'h0, cal_done};
			end else if (paddr[7:6] == 2'h0 && paddr[1:0] == 2'h0 && cal_done) begin
				prdata <= {24'h000000, rom_data};
			end else begin
				prdata <= 32'h0000_0000;
			end
		end
	end
endmodule // nvm_lock_sig
`default_nettype wire

/* File: bench/nvm_lock_sig_asserts.sv */
// assertions for the lock settings block
`timescale 1ns/1ps
`default_nettype none
module nvm_lock_sig_asserts (
	// clock, reset, status
	input wire logic        pclk, presetn, cal_done, chip_erase, sw_mem_allow, irq_mask,
	// requests
	input wire logic        spm_table_req, lpm_table_req, exec_in_boot, vectors_in_boot,
	input wire logic        prog_mem_write_req, test_if_req,
	// permissions
	input wire logic        spm_table_allow, lpm_table_allow, prog_mem_write_allow,
	input wire logic        prog_fuse_write_allow, test_if_allow,
	input wire logic [31:0] prdata
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence cal_wait; !cal_done [*6] ##1 cal_done; endsequence
	sequence erased; chip_erase [*5]; endsequence
	a_cal_timing: assert property ($rose(presetn) |-> cal_wait)
		else $error("cal load timing wrong");
	a_sw_free: assert property (sw_mem_allow) else $error("sw access blocked");
	a_upper_zero: assert property (prdata[31:8] == 24'h000000)
		else $error("prdata upper bits set");
	a_spm_cause: assert property (spm_table_allow |-> spm_table_req)
		else $error("spm allow without request");
	a_lpm_cause: assert property (lpm_table_allow |-> lpm_table_req)
		else $error("lpm allow without request");
	a_app_read: assert property (lpm_table_req && !exec_in_boot |-> lpm_table_allow)
		else $error("app code read blocked");
	a_irq_cause: assert property (irq_mask |-> vectors_in_boot && !exec_in_boot)
		else $error("irq mask without cause");
	a_fuse_test: assert property (prog_fuse_write_allow && test_if_req |-> test_if_allow)
		else $error("test blocked while open");
	a_fuse_write: assert property (prog_fuse_write_allow && prog_mem_write_req
		|-> prog_mem_write_allow) else $error("write blocked while open");
	a_erase_open: assert property (erased |-> spm_table_allow == spm_table_req
		&& test_if_allow == test_if_req) else $error("erase left locks");
endmodule // nvm_lock_sig_asserts
bind nvm_lock_sig nvm_lock_sig_asserts u_chk (.*);
`default_nettype wire

/* File: bench/prog_model.sv */
// external programmer model writing the lock byte
`timescale 1ns/1ps
`default_nettype none
module prog_model (
	// clock
	input  wire logic       pclk,
	// lock write strobe and data
	output logic            prog_wr_lock,
	output logic [7:0]      prog_lock_data
);
	initial begin
		prog_wr_lock = 1'b0;
		prog_lock_data = 8'hA5;
	end
	// whole byte at once: data set two cycles before the strobe, strobe held four cycles
	task automatic write_lock(input logic [7:0] v);
		@(posedge pclk);
		prog_lock_data <= v;
		repeat (2) @(posedge pclk);
		prog_wr_lock <= 1'b1;
		repeat (4) @(posedge pclk);
		prog_wr_lock <= 1'b0;
		repeat (4) @(posedge pclk);
		prog_lock_data <= ~v;
	endtask
endmodule // prog_model
`default_nettype wire

/* File: bench/nvm_lock_sig_bench.sv */
// self-checking bench for the lock settings block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin err_count++; \
	$display("Error %s exp %h got %h", n, e, g); end end
module nvm_lock_sig_bench;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, cal_done, chip_erase;
	logic prog_wr_lock, spm_table_req, lpm_table_req, exec_in_boot, vectors_in_boot;
	logic prog_mem_write_req, prog_mem_read_req, prog_fuse_write_req, prog_lock_read_req;
	logic test_if_req, debug_req, spm_table_allow, lpm_table_allow, irq_mask, sw_mem_allow;
	logic prog_mem_write_allow, prog_mem_read_allow, prog_fuse_write_allow;
	logic prog_lock_read_allow, test_if_allow, debug_allow;
	logic [7:0] paddr, prog_lock_data, osc2m_cal_b, osc2m_cal_a, osc32k_cal;
	logic [7:0] osc32m_cal_b, osc32m_cal_a, prot;
	logic [31:0] pwdata, prdata, r, w;
	logic [3:0] pstrb;
	logic [3:0] ix [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'h9, 4'hA};
	logic [7:0] pv [3] = '{8'hFE, 8'hFC, 8'hFF};
	int err_count, check_count;
	nvm_lock_sig uut (.*);
	prog_model prog (.*);
	function automatic logic [7:0] sig(input logic [3:0] i);
		logic [127:0] c;
		c = 128'h0000_0000_0033_2211_0000_0000_5544_3322;
		return c[i*8+:8];
	endfunction
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		`CHK("slverr", 1'b0, pslverr)
		{psel, penable} <= 2'b00;
	endtask
	task automatic perm(input logic [7:0] p);
		apb(1'b0, 8'h40, 32'h0);
		`CHK("prot", p, r[7:0])
		repeat (8) begin
			@(posedge pclk);
			{spm_table_req, lpm_table_req, exec_in_boot, vectors_in_boot, prog_mem_write_req,
				prog_mem_read_req, prog_fuse_write_req, prog_lock_read_req, test_if_req,
				debug_req} <= 10'($urandom);
			@(negedge pclk);
			`CHK("spm", spm_table_req & p[2], spm_table_allow)
			`CHK("lpm", lpm_table_req & ~(~p[3] & exec_in_boot), lpm_table_allow)
			`CHK("irq", ~p[3] & vectors_in_boot & ~exec_in_boot, irq_mask)
			`CHK("pw", prog_mem_write_req & (p[1:0] == 2'h3), prog_mem_write_allow)
			`CHK("pr", prog_mem_read_req & p[1], prog_mem_read_allow)
			`CHK("fw", prog_fuse_write_req & (p[1:0] == 2'h3), prog_fuse_write_allow)
			`CHK("lr", prog_lock_read_req & p[1], prog_lock_read_allow)
			`CHK("tif", test_if_req & (p[1:0] == 2'h3), test_if_allow)
			`CHK("dbg", debug_req & (p[1:0] == 2'h3), debug_allow)
			`CHK("sw", 1'b1, sw_mem_allow)
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	initial begin
		repeat (20000) @(posedge pclk);
		err_count++;
		$display("Error watchdog exp done got hang");
		end_of_test;
	end
	initial begin
		void'($urandom(32'h7ca009fd));
		{psel, penable, pwrite, paddr, pwdata, chip_erase, r} = '0;
		{spm_table_req, lpm_table_req, exec_in_boot, vectors_in_boot, debug_req} = '0;
		{prog_mem_write_req, prog_mem_read_req, prog_fuse_write_req} = '0;
		{prog_lock_read_req, test_if_req} = '0;
		{pstrb, presetn, prot} = {4'h1, 1'b0, 8'hFF};
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		repeat (8) @(posedge pclk);
		`CHK("c2b", sig(4'h0), osc2m_cal_b)
		`CHK("c2a", sig(4'h1), osc2m_cal_a)
		`CHK("c32k", sig(4'h2), osc32k_cal)
		`CHK("c32b", sig(4'h3), osc32m_cal_b)
		`CHK("c32a", sig(4'h4), osc32m_cal_a)
		apb(1'b0, 8'h44, 32'h0);
		`CHK("caldone", 32'h1, r)
		foreach (ix[i]) begin
			apb(1'b1, {2'b00, ix[i], 2'b00}, $urandom);
			apb(1'b0, {2'b00, ix[i], 2'b00}, 32'h0);
			`CHK("sig", {24'h0, sig(ix[i])}, r)
		end
		apb(1'b0, 8'h80, 32'h0);
		`CHK("unmapped", 32'h0, r)
		$display("test calibration and signature done");
		perm(prot);
		apb(1'b1, 8'h40, 32'hF7);
		prot = prot & 8'hF7;
		perm(prot);
		@(posedge pclk);
		pstrb <= 4'h0;
		apb(1'b1, 8'h40, 32'h0);
		pstrb <= 4'h1;
		perm(prot);
		repeat (6) begin
			w = $urandom;
			apb(1'b1, 8'h40, w);
			prot = prot & (w[7:0] | 8'h03);
			perm(prot);
			apb(1'b1, 8'h40, 32'hFF);
			perm(prot);
		end
		$display("test software writes done");
		foreach (pv[i]) begin
			prog.write_lock(pv[i]);
			prot = prot & pv[i];
			perm(prot);
		end
		@(posedge pclk);
		chip_erase <= 1'b1;
		repeat (4) @(posedge pclk);
		prot = 8'hFF;
		perm(prot);
		@(posedge pclk);
		chip_erase <= 1'b0;
		prog.write_lock(8'hFD);
		perm(8'hFD);
		apb(1'b1, 8'h40, 32'hFB);
		perm(8'hF9);
		$display("test programmer and erase done");
		end_of_test;
	end
endmodule // nvm_lock_sig_bench
`default_nettype wire
